// ---- hdl/afc_pkg.sv ----
// Package for the audio filter coefficient bank: map, reset image, carriers
package afc_pkg;

  // ==========================================================================
  // Register map (page 1 register numbers)
  localparam int AFC_ADDR_W = 7;
  localparam int AFC_DATA_W = 8;
  localparam int AFC_NUM_REGS = 9;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_LEFT_DEEMPH_DEN_HIGH = 7'h19;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_LEFT_DEEMPH_DEN_LOW = 7'h1a;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_RIGHT_FX_NUM0_HIGH = 7'h1b;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_RIGHT_FX_NUM0_LOW = 7'h1c;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_RIGHT_FX_NUM1_HIGH = 7'h1d;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_RIGHT_FX_NUM1_LOW = 7'h1e;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_RIGHT_FX_NUM2_HIGH = 7'h1f;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_RIGHT_FX_NUM2_LOW = 7'h20;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_RIGHT_FX_NUM3_HIGH = 7'h21;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_BASE = AFC_ADDR_LEFT_DEEMPH_DEN_HIGH;
  localparam logic [AFC_ADDR_W-1:0] AFC_ADDR_LAST = AFC_ADDR_RIGHT_FX_NUM3_HIGH;

  // ==========================================================================
  // Storage index of each byte (address minus base)
  localparam int AFC_IDX_DEN_HIGH = 0;
  localparam int AFC_IDX_DEN_LOW = 1;
  localparam int AFC_IDX_NUM0_HIGH = 2;
  localparam int AFC_IDX_NUM0_LOW = 3;
  localparam int AFC_IDX_NUM1_HIGH = 4;
  localparam int AFC_IDX_NUM1_LOW = 5;
  localparam int AFC_IDX_NUM2_HIGH = 6;
  localparam int AFC_IDX_NUM2_LOW = 7;
  localparam int AFC_IDX_NUM3_HIGH = 8;

  // ==========================================================================
  // Reset values
  localparam logic [AFC_DATA_W-1:0] AFC_RST_DEN_HIGH = 8'h53;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_DEN_LOW = 8'h7e;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_NUM0_HIGH = 8'h6b;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_NUM0_LOW = 8'he3;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_NUM1_HIGH = 8'h96;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_NUM1_LOW = 8'h66;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_NUM2_HIGH = 8'h67;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_NUM2_LOW = 8'h5d;
  localparam logic [AFC_DATA_W-1:0] AFC_RST_NUM3_HIGH = 8'h6b;
  localparam logic [AFC_NUM_REGS-1:0][AFC_DATA_W-1:0] AFC_RESET_IMAGE = {
    AFC_RST_NUM3_HIGH, AFC_RST_NUM2_LOW, AFC_RST_NUM2_HIGH, AFC_RST_NUM1_LOW,
    AFC_RST_NUM1_HIGH, AFC_RST_NUM0_LOW, AFC_RST_NUM0_HIGH, AFC_RST_DEN_LOW,
    AFC_RST_DEN_HIGH};
  localparam logic [AFC_DATA_W-1:0] AFC_UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [AFC_ADDR_W-1:0] addr;
    logic [AFC_DATA_W-1:0] wr_data;
  } afc_req_type;

  typedef struct packed {
    logic rd_valid;
    logic rd_hit;
    logic [AFC_DATA_W-1:0] rd_data;
  } afc_rsp_type;

  typedef struct packed {
    logic signed [15:0] deemph_denominator;
    logic signed [15:0] numerator_zero;
    logic signed [15:0] numerator_one;
    logic signed [15:0] numerator_two;
    logic [AFC_DATA_W-1:0] numerator_three_high;
  } afc_coef_type;

  typedef struct packed {
    logic [AFC_NUM_REGS-1:0][AFC_DATA_W-1:0] bytes;
    afc_rsp_type rsp;
  } afc_state_type;

endpackage : afc_pkg

// ---- hdl/afc_coef_bank.sv ----
// Coefficient register bank for the de-emphasis and right effects filters
`timescale 1ns/100ps
// Function
// [RULE1] Each coefficient is the high byte in bits 15..8 joined with the low byte in bits 7..0.
// [RULE2] Each joined coefficient is handed to the filter as a signed two's complement value.
// [RULE3] The de-emphasis denominator low byte is a read/write byte resetting to 0x7e.
// [RULE4] Numerator zero resets to high 0x6b and low 0xe3, both bytes read/write.
// [RULE5] Numerator one resets to high 0x96 and low 0x66, both bytes read/write.
// [RULE6] Numerator two resets to high 0x67 and low 0x5d, both bytes read/write.
// [RULE7] The numerator three high byte is a read/write byte resetting to 0x6b.
// [RULE8] The de-emphasis denominator high byte is a read/write byte resetting to 0x53.
// [RULE9] A byte keeps its last written value until overwritten or reset; reads change nothing.
module afc_coef_bank (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire afc_pkg::afc_req_type req_in,
  output afc_pkg::afc_rsp_type rsp_out,
  output afc_pkg::afc_coef_type coef_out
);

  // ==========================================================================
  // State
  afc_pkg::afc_state_type state;
  afc_pkg::afc_state_type next_state;
  logic addr_hit;
  logic [afc_pkg::AFC_ADDR_W-1:0] addr_index;

  // Only the nine bytes of this bank answer; the rest of the page lives elsewhere
  assign addr_hit = (req_in.addr >= afc_pkg::AFC_ADDR_BASE) &&
                    (req_in.addr <= afc_pkg::AFC_ADDR_LAST);
  assign addr_index = req_in.addr - afc_pkg::AFC_ADDR_BASE;

  // ==========================================================================
  // Next state
  always_comb begin
    next_state = state;
    next_state.rsp.rd_valid = req_in.rd_en;
    next_state.rsp.rd_hit = req_in.rd_en && addr_hit;
    next_state.rsp.rd_data = afc_pkg::AFC_UNMAPPED_READ;
    // Read sees the old byte when a write hits the same address in that cycle
    if (req_in.rd_en && addr_hit) begin
      next_state.rsp.rd_data = state.bytes[addr_index[3:0]]; // [RULE9]
    end
    for (int i = 0; i < afc_pkg::AFC_NUM_REGS; i++) begin
      if (req_in.wr_en && addr_hit && (addr_index == 7'(i))) begin
        next_state.bytes[i] = req_in.wr_data; // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state.bytes <= afc_pkg::AFC_RESET_IMAGE; // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
      state.rsp <= '0;
    end else begin
      state <= next_state; // [RULE9]
    end
  end

  // ==========================================================================
  // Outputs, taken straight from the byte and read response flops
  assign rsp_out = state.rsp;
  assign coef_out.deemph_denominator = $signed({state.bytes[afc_pkg::AFC_IDX_DEN_HIGH],
    state.bytes[afc_pkg::AFC_IDX_DEN_LOW]}); // [RULE1] [RULE2]
  assign coef_out.numerator_zero = $signed({state.bytes[afc_pkg::AFC_IDX_NUM0_HIGH],
    state.bytes[afc_pkg::AFC_IDX_NUM0_LOW]}); // [RULE1] [RULE2]
  assign coef_out.numerator_one = $signed({state.bytes[afc_pkg::AFC_IDX_NUM1_HIGH],
    state.bytes[afc_pkg::AFC_IDX_NUM1_LOW]}); // [RULE1] [RULE2]
  assign coef_out.numerator_two = $signed({state.bytes[afc_pkg::AFC_IDX_NUM2_HIGH],
    state.bytes[afc_pkg::AFC_IDX_NUM2_LOW]}); // [RULE1] [RULE2]
  // Low byte of numerator three sits in a neighbouring bank, so only the high half is here
  assign coef_out.numerator_three_high = state.bytes[afc_pkg::AFC_IDX_NUM3_HIGH]; // [RULE7]

  // ==========================================================================
  // Checks
  logic fresh;
  logic [afc_pkg::AFC_DATA_W-1:0] hit_byte;

  assign hit_byte = state.bytes[addr_index[3:0]];

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fresh <= 1'h1;
    end else begin
      fresh <= 1'h0;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  den_reset_a: assert property (fresh // [RULE3] [RULE8]
    |-> (coef_out.deemph_denominator[7:0] == 8'h7e
    && coef_out.deemph_denominator[15:8] == 8'h53))
    else $error("Denominator bytes not at reset value");

  num0_reset_a: assert property (fresh |-> coef_out.numerator_zero == 16'sh6be3) // [RULE4]
    else $error("Numerator zero not at reset value");

  num1_reset_a: assert property (fresh |-> coef_out.numerator_one == 16'sh9666) // [RULE5]
    else $error("Numerator one not at reset value");

  num2_reset_a: assert property (fresh |-> coef_out.numerator_two == 16'sh675d) // [RULE6]
    else $error("Numerator two not at reset value");

  num3_reset_a: assert property (fresh |-> coef_out.numerator_three_high == 8'h6b) // [RULE7]
    else $error("Numerator three high not at reset value");

  write_lands_a: assert property (req_in.wr_en && addr_hit ##1 req_in.rd_en // [RULE9]
    && (req_in.addr == $past(req_in.addr)) |=> rsp_out.rd_data == $past(req_in.wr_data, 2))
    else $error("Written byte not read back");

  hold_bytes_a: assert property (!req_in.wr_en |=> $stable(state.bytes)) // [RULE9]
    else $error("Bytes changed without a write");

  read_value_a: assert property (req_in.rd_en && addr_hit |=> rsp_out.rd_valid // [RULE9]
    && rsp_out.rd_hit && rsp_out.rd_data == $past(hit_byte))
    else $error("Read returned wrong byte");

  unmapped_read_a: assert property (req_in.rd_en && !addr_hit |=> rsp_out.rd_valid
    && !rsp_out.rd_hit && rsp_out.rd_data == afc_pkg::AFC_UNMAPPED_READ)
    else $error("Unmapped read not zero");

  num0_join_a: assert property (req_in.wr_en // [RULE1]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM0_HIGH
    |=> coef_out.numerator_zero[15:8] == $past(req_in.wr_data)
    && $stable(coef_out.numerator_zero[7:0]))
    else $error("High byte not in upper half");

  sign_follow_a: assert property (req_in.wr_en // [RULE2]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM2_HIGH
    && req_in.wr_data[7] |=> coef_out.numerator_two < 0)
    else $error("Coefficient not negative with high bit set");

  den_low_join_a: assert property (req_in.wr_en // [RULE1]
    && req_in.addr == afc_pkg::AFC_ADDR_LEFT_DEEMPH_DEN_LOW
    |=> coef_out.deemph_denominator[7:0] == $past(req_in.wr_data)
    && $stable(coef_out.deemph_denominator[15:8]))
    else $error("Low byte not in lower half");

  // ==========================================================================
  // Response idle and reset
  rsp_reset_a: assert property (fresh |-> rsp_out == '0)
    else $error("Read response not cleared by reset");

  rd_idle_a: assert property (!req_in.rd_en |=> !rsp_out.rd_valid && !rsp_out.rd_hit
    && rsp_out.rd_data == afc_pkg::AFC_UNMAPPED_READ)
    else $error("Read response without a read");

  // ==========================================================================
  // Per-byte reset; fixed addresses, so a slip in the index arithmetic cannot hide
  den_high_reset_a: assert property (fresh // [RULE8]
    |-> coef_out.deemph_denominator[15:8] == afc_pkg::AFC_RST_DEN_HIGH)
    else $error("Denominator high byte not at reset value");

  den_low_reset_a: assert property (fresh // [RULE3]
    |-> coef_out.deemph_denominator[7:0] == afc_pkg::AFC_RST_DEN_LOW)
    else $error("Denominator low byte not at reset value");

  num0_high_reset_a: assert property (fresh // [RULE4]
    |-> coef_out.numerator_zero[15:8] == afc_pkg::AFC_RST_NUM0_HIGH)
    else $error("Numerator zero high byte not at reset value");

  num0_low_reset_a: assert property (fresh // [RULE4]
    |-> coef_out.numerator_zero[7:0] == afc_pkg::AFC_RST_NUM0_LOW)
    else $error("Numerator zero low byte not at reset value");

  num1_high_reset_a: assert property (fresh // [RULE5]
    |-> coef_out.numerator_one[15:8] == afc_pkg::AFC_RST_NUM1_HIGH)
    else $error("Numerator one high byte not at reset value");

  num1_low_reset_a: assert property (fresh // [RULE5]
    |-> coef_out.numerator_one[7:0] == afc_pkg::AFC_RST_NUM1_LOW)
    else $error("Numerator one low byte not at reset value");

  num2_high_reset_a: assert property (fresh // [RULE6]
    |-> coef_out.numerator_two[15:8] == afc_pkg::AFC_RST_NUM2_HIGH)
    else $error("Numerator two high byte not at reset value");

  num2_low_reset_a: assert property (fresh // [RULE6]
    |-> coef_out.numerator_two[7:0] == afc_pkg::AFC_RST_NUM2_LOW)
    else $error("Numerator two low byte not at reset value");

  num3_high_reset_a: assert property (fresh // [RULE7]
    |-> coef_out.numerator_three_high == afc_pkg::AFC_RST_NUM3_HIGH)
    else $error("Numerator three high byte not at reset value");

  // ==========================================================================
  // Per-byte write lands one cycle after it is taken
  den_high_write_a: assert property (req_in.wr_en // [RULE8]
    && req_in.addr == afc_pkg::AFC_ADDR_LEFT_DEEMPH_DEN_HIGH
    |=> coef_out.deemph_denominator[15:8] == $past(req_in.wr_data))
    else $error("Denominator high byte write lost");

  den_low_write_a: assert property (req_in.wr_en // [RULE3]
    && req_in.addr == afc_pkg::AFC_ADDR_LEFT_DEEMPH_DEN_LOW
    |=> coef_out.deemph_denominator[7:0] == $past(req_in.wr_data))
    else $error("Denominator low byte write lost");

  num0_high_write_a: assert property (req_in.wr_en // [RULE4]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM0_HIGH
    |=> coef_out.numerator_zero[15:8] == $past(req_in.wr_data))
    else $error("Numerator zero high byte write lost");

  num0_low_write_a: assert property (req_in.wr_en // [RULE4]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM0_LOW
    |=> coef_out.numerator_zero[7:0] == $past(req_in.wr_data))
    else $error("Numerator zero low byte write lost");

  num1_high_write_a: assert property (req_in.wr_en // [RULE5]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM1_HIGH
    |=> coef_out.numerator_one[15:8] == $past(req_in.wr_data))
    else $error("Numerator one high byte write lost");

  num1_low_write_a: assert property (req_in.wr_en // [RULE5]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM1_LOW
    |=> coef_out.numerator_one[7:0] == $past(req_in.wr_data))
    else $error("Numerator one low byte write lost");

  num2_high_write_a: assert property (req_in.wr_en // [RULE6]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM2_HIGH
    |=> coef_out.numerator_two[15:8] == $past(req_in.wr_data))
    else $error("Numerator two high byte write lost");

  num2_low_write_a: assert property (req_in.wr_en // [RULE6]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM2_LOW
    |=> coef_out.numerator_two[7:0] == $past(req_in.wr_data))
    else $error("Numerator two low byte write lost");

  num3_high_write_a: assert property (req_in.wr_en // [RULE7]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM3_HIGH
    |=> coef_out.numerator_three_high == $past(req_in.wr_data))
    else $error("Numerator three high byte write lost");

  // ==========================================================================
  // Per-byte read returns the byte as it stood when the read was taken
  den_high_read_a: assert property (req_in.rd_en // [RULE8]
    && req_in.addr == afc_pkg::AFC_ADDR_LEFT_DEEMPH_DEN_HIGH
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.deemph_denominator[15:8]))
    else $error("Denominator high byte read wrong");

  den_low_read_a: assert property (req_in.rd_en // [RULE3]
    && req_in.addr == afc_pkg::AFC_ADDR_LEFT_DEEMPH_DEN_LOW
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.deemph_denominator[7:0]))
    else $error("Denominator low byte read wrong");

  num0_high_read_a: assert property (req_in.rd_en // [RULE4]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM0_HIGH
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.numerator_zero[15:8]))
    else $error("Numerator zero high byte read wrong");

  num0_low_read_a: assert property (req_in.rd_en // [RULE4]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM0_LOW
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.numerator_zero[7:0]))
    else $error("Numerator zero low byte read wrong");

  num1_high_read_a: assert property (req_in.rd_en // [RULE5]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM1_HIGH
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.numerator_one[15:8]))
    else $error("Numerator one high byte read wrong");

  num1_low_read_a: assert property (req_in.rd_en // [RULE5]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM1_LOW
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.numerator_one[7:0]))
    else $error("Numerator one low byte read wrong");

  num2_high_read_a: assert property (req_in.rd_en // [RULE6]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM2_HIGH
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.numerator_two[15:8]))
    else $error("Numerator two high byte read wrong");

  num2_low_read_a: assert property (req_in.rd_en // [RULE6]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM2_LOW
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.numerator_two[7:0]))
    else $error("Numerator two low byte read wrong");

  num3_high_read_a: assert property (req_in.rd_en // [RULE7]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM3_HIGH
    |=> rsp_out.rd_hit && rsp_out.rd_data == $past(coef_out.numerator_three_high))
    else $error("Numerator three high byte read wrong");

  // ==========================================================================
  // Per-byte hold; a write to any other address, mapped or not, leaves the byte alone
  den_high_hold_a: assert property (!(req_in.wr_en // [RULE8] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_LEFT_DEEMPH_DEN_HIGH)
    |=> $stable(coef_out.deemph_denominator[15:8]))
    else $error("Denominator high byte changed without its write");

  den_low_hold_a: assert property (!(req_in.wr_en // [RULE3] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_LEFT_DEEMPH_DEN_LOW)
    |=> $stable(coef_out.deemph_denominator[7:0]))
    else $error("Denominator low byte changed without its write");

  num0_high_hold_a: assert property (!(req_in.wr_en // [RULE4] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM0_HIGH)
    |=> $stable(coef_out.numerator_zero[15:8]))
    else $error("Numerator zero high byte changed without its write");

  num0_low_hold_a: assert property (!(req_in.wr_en // [RULE4] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM0_LOW)
    |=> $stable(coef_out.numerator_zero[7:0]))
    else $error("Numerator zero low byte changed without its write");

  num1_high_hold_a: assert property (!(req_in.wr_en // [RULE5] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM1_HIGH)
    |=> $stable(coef_out.numerator_one[15:8]))
    else $error("Numerator one high byte changed without its write");

  num1_low_hold_a: assert property (!(req_in.wr_en // [RULE5] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM1_LOW)
    |=> $stable(coef_out.numerator_one[7:0]))
    else $error("Numerator one low byte changed without its write");

  num2_high_hold_a: assert property (!(req_in.wr_en // [RULE6] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM2_HIGH)
    |=> $stable(coef_out.numerator_two[15:8]))
    else $error("Numerator two high byte changed without its write");

  num2_low_hold_a: assert property (!(req_in.wr_en // [RULE6] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM2_LOW)
    |=> $stable(coef_out.numerator_two[7:0]))
    else $error("Numerator two low byte changed without its write");

  num3_high_hold_a: assert property (!(req_in.wr_en // [RULE7] [RULE9]
    && req_in.addr == afc_pkg::AFC_ADDR_RIGHT_FX_NUM3_HIGH)
    |=> $stable(coef_out.numerator_three_high))
    else $error("Numerator three high byte changed without its write");

endmodule : afc_coef_bank

// ---- verification/afc_coef_bank_tb_top.sv ----
// Self-checking testbench for the coefficient register bank
`timescale 1ns/100ps
module afc_coef_bank_tb_top;
  // ==========================================================================
  // Stimulus and bookkeeping
  logic ref_clk_in;
  logic rst_n_in;
  afc_pkg::afc_req_type req;
  afc_pkg::afc_rsp_type rsp;
  afc_pkg::afc_coef_type coef;
  int error_cnt;
  int checks;
  localparam logic [8:0][7:0] RST_IMG = {8'h6b, 8'h5d, 8'h67, 8'h66, 8'h96, 8'he3, 8'h6b, 8'h7e,
    8'h53};
  logic [8:0][7:0] model;

  afc_coef_bank afc_coef_bank_i (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req),
    .rsp_out(rsp),
    .coef_out(coef)
  );

  initial begin
    ref_clk_in = 1'h0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================================
  // Shared tasks; every task starts and ends at a falling edge
  task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Request is left standing; repeating a write or read is harmless
  task automatic access(input logic wr, input logic rd, input logic [6:0] a, input logic [7:0] d);
    req = '{wr_en: wr, rd_en: rd, addr: a, wr_data: d};
    @(negedge ref_clk_in);
  endtask : access

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input logic hit);
    access(1'h0, 1'h1, a, 8'h00);
    chk({62'h0, rsp.rd_valid, rsp.rd_hit, rsp.rd_data},
      {62'h0, 1'h1, hit, exp}, "read");
  endtask : rd_chk

  task automatic coef_chk();
    chk(coef, {model[0], model[1], model[2], model[3], model[4], model[5],
      model[6], model[7], model[8]}, "coefficients");
  endtask : coef_chk

  task automatic read_all();
    for (int i = 0; i < 9; i++) begin
      rd_chk(7'h19 + 7'(i), model[i], 1'h1);
    end
    coef_chk();
  endtask : read_all

  // ==========================================================================
  // Scenarios
  task automatic t_write_all();
    for (int i = 0; i < 9; i++) begin
      model[i] = 8'ha5 ^ 8'(i * 17);
      access(1'h1, 1'h0, 7'h19 + 7'(i), model[i]);
    end
    read_all();
  endtask : t_write_all

  task automatic t_signed();
    access(1'h1, 1'h0, 7'h1b, 8'h80);
    access(1'h1, 1'h0, 7'h1c, 8'h00);
    chk({56'h0, coef.numerator_zero}, {56'h0, 16'h8000}, "most negative");
    chk({71'h0, coef.numerator_zero < 0}, 72'h1, "sign");
    access(1'h1, 1'h0, 7'h1b, 8'h7f);
    access(1'h1, 1'h0, 7'h1c, 8'hff);
    chk({56'h0, coef.numerator_zero}, {56'h0, 16'h7fff}, "most positive value");
    chk({71'h0, coef.numerator_zero > 0}, 72'h1, "most positive");
    model[2] = 8'h7f;
    model[3] = 8'hff;
  endtask : t_signed

  // Writes just outside the bank must not alias onto its edge bytes
  task automatic t_unmapped();
    access(1'h1, 1'h0, 7'h18, 8'hff);
    access(1'h1, 1'h0, 7'h22, 8'hff);
    rd_chk(7'h18, 8'h00, 1'h0);
    rd_chk(7'h22, 8'h00, 1'h0);
    read_all();
  endtask : t_unmapped

  task automatic t_read_write();
    access(1'h1, 1'h1, 7'h21, 8'h3c);
    chk({63'h0, rsp.rd_valid, rsp.rd_data}, {63'h0, 1'h1, model[8]}, "old data");
    model[8] = 8'h3c;
    // Read straight after the write, so the back-to-back path is exercised
    rd_chk(7'h21, 8'h3c, 1'h1);
    access(1'h0, 1'h0, 7'h21, 8'h00);
    chk({71'h0, rsp.rd_valid}, 72'h0, "valid pulse");
    read_all();
  endtask : t_read_write

  task automatic t_mid_reset();
    rst_n_in = 1'h0;
    @(negedge ref_clk_in);
    model = RST_IMG;
    coef_chk();
    rst_n_in = 1'h1;
    @(negedge ref_clk_in);
    read_all();
  endtask : t_mid_reset

  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial begin
    req = '0;
    rst_n_in = 1'h0;
    error_cnt = 0;
    checks = 0;
    model = RST_IMG;
    repeat (8) @(negedge ref_clk_in);
    rst_n_in = 1'h1;
    read_all();
    t_write_all();
    t_signed();
    t_unmapped();
    t_read_write();
    t_mid_reset();
    complete_run();
  end
endmodule : afc_coef_bank_tb_top
